// ### logic/as_consts.vh
/*
 Constants for the serial port and output-period logic of the converter.
 Assumes inclusion by bare name from the design files under logic/.
*/
`ifndef AS_CONSTS_VH
`define AS_CONSTS_VH
// Command byte layout
`define AS_CMD_ADDR_HI 7
`define AS_CMD_ADDR_LO 3
`define AS_CMD_RD_BIT 2
// Register addresses
`define AS_A_CUR 5'h00
`define AS_A_V1 5'h01
`define AS_A_V2 5'h02
`define AS_A_CRC 5'h03
`define AS_A_STAT 5'h04
`define AS_A_CFG 5'h05
`define AS_A_SNAP 5'h06
`define AS_A_CLO 5'h07
`define AS_A_CHI 5'h08
`define AS_A_SYNC 5'h09
// Register widths in bits
`define AS_W_WAVE 6'h18
`define AS_W_HALF 6'h10
`define AS_W_BYTE 6'h08
// Configuration fields and reset
`define AS_CFG_CLKSEL 0
`define AS_CFG_RATE_HI 5
`define AS_CFG_RATE_LO 4
`define AS_CFG_RST 8'h00
// Sync-capture control bits
`define AS_SYNC_BIT 0
`define AS_SNAP_BIT 1
// Burst sequence
`define AS_BURST_LAST 3'h5
// Period counter reload values per rate code
`define AS_RELOAD0 12'h1FF
`define AS_RELOAD1 12'h3FF
`define AS_RELOAD2 12'h7FF
`define AS_RELOAD3 12'hFFF
// Ready strobe length in core clock cycles
`define AS_RDY_CYC 7'h40
`endif

// ### logic/as_port.v
/*
 Serial slave port of a multi-channel converter with output-period
 alignment: command decode, single and burst reads, byte writes, sync,
 snapshot, 12-bit period counter and the clock-or-ready pin.
 Assumes CLK is the core clock, the serial pins arrive asynchronously
 and SCLK runs well below a quarter of CLK. Sample words come from
 converter logic on CLK.
*/
`timescale 1ns/1ns
`include "as_consts.vh"

// Small write-path FIFO, depth a power of two
module as_fifo #(
   parameter W = 13,
   parameter D = 4,
   parameter AW = 2
) (
   input wire clk,
   input wire rst,
   input wire in_valid,
   output wire in_ready,
   input wire [W-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [W-1:0] out_data
);
   localparam [AW:0] FULL = D[AW:0];
   reg [W-1:0] mem [0:D-1];
   reg [AW-1:0] wp;
   reg [AW-1:0] rp;
   reg [AW:0] cnt;
   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;
   // Honest full and empty from the fill count
   assign in_ready = (cnt != FULL);
   assign out_valid = (cnt != {(AW+1){1'b0}});
   assign out_data = mem[rp];
   // Storage needs no reset
   always @(posedge clk) begin
      if (push) begin
         mem[wp] <= in_data;
      end
   end
   // Pointers wrap naturally
   always @(posedge clk) begin
      if (rst) begin
         wp <= {AW{1'b0}};
         rp <= {AW{1'b0}};
         cnt <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wp <= wp + 1'b1;
         end
         if (pop) begin
            rp <= rp + 1'b1;
         end
         if (push && !pop) begin
            cnt <= cnt + 1'b1;
         end else if (pop && !push) begin
            cnt <= cnt - 1'b1;
         end
      end
   end
endmodule

//  Operation
// - Command bits 7:3 carry the register address.
// - Command bit 2 set means read, clear means write.
// - Command bits 1:0 are ignored.
// - Input bits are captured on rising serial clock edges.
// - Read data starts on the falling edge after the last command bit.
// - Chip select high ends the transfer and releases the output.
// - 8, 16 and 24-bit reads differ only in bit count.
// - Read of address 0 starts a burst with the current sample.
// - Burst order: current, voltage one, voltage two, CRC, status, capture.
// - Host may stop a burst anytime by raising chip select.
// - Read of address 1 starts a burst at the first voltage sample.
// - Only byte writes; counter start written low byte then high byte.
// - Writes get no acknowledgement, so broadcast is safe.
// - Configuration bit 0 picks ready strobe (0) or clock output (1).
// - Configuration bits 5:4 select output rate; same on every device.
// - Writing sync bit starts a new output period at once.
// - Sync bit clears itself one core clock later.
// - Ready strobe drives low 64 core cycles at each period start.
// - A 12-bit counter runs on the core clock aligned to the period.
// - Counter reloads each period from the rate-selected start value.
// - All words shift most significant bit first.
// - Chip select rising mid-transfer aborts and leaves registers unchanged.
// - Reload values 511, 1023, 2047, 4095 for rate codes 0 to 3.
// - Writing snap bit captures the counter, then the bit self-clears.
module as_port (
   input wire CLK,
   input wire RST,
   input wire CS_N,
   input wire SCLK,
   input wire MOSI,
   output wire MISO,
   output wire MISO_OE_N,
   output wire CLK_OR_RDY,
   input wire [23:0] CUR_SAMPLE,
   input wire [23:0] V1_SAMPLE,
   input wire [23:0] V2_SAMPLE,
   input wire [15:0] CRC_WORD,
   input wire [7:0] STATUS_WORD
);
   // Pin synchronisers
   reg [1:0] cs_sy, sclk_sy, mosi_sy;
   reg sclk_d;
   // Serial engine
   reg [4:0] rx_cnt;
   reg [7:0] rx;
   reg [4:0] cmd_addr;
   reg is_rd;
   reg tx_on;
   reg burst;
   reg [2:0] bidx;
   reg [31:0] sh;
   reg [5:0] left;
   reg miso;
   reg oe_n;
   reg wpend;
   reg [12:0] wdata;
   // Register file and period logic
   reg [23:0] cur_q, v1_q, v2_q;
   reg [15:0] crc_q;
   reg [7:0] stat_q;
   reg [11:0] snap_q;
   reg [7:0] cfg;
   reg [7:0] clo;
   reg [3:0] chi;
   reg [1:0] sync_ctl;
   reg ld_start;
   reg [11:0] cnt;
   reg [6:0] rdy_cnt;
   reg clk_div;
   reg pin_q;
   wire f_in_ready;
   wire f_out_valid;
   wire f_out_ready;
   wire [12:0] f_out_data;
   // Synchronised pins and serial clock edges
   wire cs_n = cs_sy[1];
   wire mosi_s = mosi_sy[1];
   wire s_rise = sclk_sy[1] & ~sclk_d;
   wire s_fall = ~sclk_sy[1] & sclk_d;
   // Byte as it stands after this rising edge
   wire [7:0] nb = {rx[6:0], mosi_s};
   // Width of a register in bits
   function [5:0] width_of;
      input [4:0] a;
      begin
         case (a)
            `AS_A_CUR, `AS_A_V1, `AS_A_V2: width_of = `AS_W_WAVE;
            `AS_A_CRC, `AS_A_SNAP: width_of = `AS_W_HALF;
            default: width_of = `AS_W_BYTE;
         endcase
      end
   endfunction
   // Register word, left aligned; unmapped reads zero
   function [31:0] value_of;
      input [4:0] a;
      begin
         case (a)
            `AS_A_CUR: value_of = {cur_q, 8'h00};
            `AS_A_V1: value_of = {v1_q, 8'h00};
            `AS_A_V2: value_of = {v2_q, 8'h00};
            `AS_A_CRC: value_of = {crc_q, 16'h0000};
            `AS_A_STAT: value_of = {stat_q, 24'h000000};
            `AS_A_CFG: value_of = {cfg, 24'h000000};
            `AS_A_SNAP: value_of = {4'h0, snap_q, 16'h0000};
            `AS_A_CLO: value_of = {clo, 24'h000000};
            `AS_A_CHI: value_of = {4'h0, chi, 24'h000000};
            `AS_A_SYNC: value_of = {6'h00, sync_ctl, 24'h000000};
            default: value_of = 32'h00000000;
         endcase
      end
   endfunction
   // Burst position to address; the capture word skips configuration
   function [4:0] burst_addr;
      input [2:0] i;
      begin
         burst_addr = (i == `AS_BURST_LAST) ? `AS_A_SNAP : {2'b00, i};
      end
   endfunction
   // Period counter reload value per rate code, one less than the period length
   function [11:0] reload_of;
      input [1:0] r;
      begin
         case (r)
            2'b00: reload_of = `AS_RELOAD0;
            2'b01: reload_of = `AS_RELOAD1;
            2'b10: reload_of = `AS_RELOAD2;
            default: reload_of = `AS_RELOAD3;
         endcase
      end
   endfunction
   // Next burst word, and the word a command addresses
   wire [4:0] nxt_addr = burst_addr(bidx + 3'h1);
   wire [31:0] nxt_val = value_of(nxt_addr);
   wire [31:0] cmd_val = value_of(nb[`AS_CMD_ADDR_HI:`AS_CMD_ADDR_LO]);
   // Two flops on every pin before use
   always @(posedge CLK) begin
      if (RST) begin
         cs_sy <= 2'h3;
         sclk_sy <= 2'h3;
         mosi_sy <= 2'h0;
         sclk_d <= 1'b1;
      end else begin
         cs_sy <= {cs_sy[0], CS_N};
         sclk_sy <= {sclk_sy[0], SCLK};
         mosi_sy <= {mosi_sy[0], MOSI};
         sclk_d <= sclk_sy[1];
      end
   end
   // Serial engine: command, read shifter, write capture
   always @(posedge CLK) begin
      if (RST) begin
         rx_cnt <= 5'h00;
         rx <= 8'h00;
         cmd_addr <= 5'h00;
         is_rd <= 1'b0;
         tx_on <= 1'b0;
         burst <= 1'b0;
         bidx <= 3'h0;
         sh <= 32'h00000000;
         left <= 6'h00;
         miso <= 1'b0;
         oe_n <= 1'b1;
         wpend <= 1'b0;
         wdata <= 13'h0000;
      end else begin
         // Pending write leaves once the FIFO has room
         if (wpend && f_in_ready) begin
            wpend <= 1'b0;
         end
         if (cs_n) begin
            rx_cnt <= 5'h00;
            tx_on <= 1'b0;
            oe_n <= 1'b1;
            miso <= 1'b0;
         end else begin
            if (s_rise) begin
               rx <= nb;
               if (rx_cnt != 5'h1F) begin
                  rx_cnt <= rx_cnt + 5'h01;
               end
               if (rx_cnt == 5'h07) begin
                  cmd_addr <= nb[`AS_CMD_ADDR_HI:`AS_CMD_ADDR_LO];
                  is_rd <= nb[`AS_CMD_RD_BIT];
                  if (nb[`AS_CMD_RD_BIT]) begin
                     // width sets only the bit count
                     tx_on <= 1'b1;
                     sh <= cmd_val;
                     left <= width_of(nb[`AS_CMD_ADDR_HI:`AS_CMD_ADDR_LO]);
                     // burst from address 0 or 1
                     burst <= (nb[7:4] == 4'h0);
                     bidx <= {2'b00, nb[3]};
                  end
               end
               if (rx_cnt == 5'h0F && !is_rd) begin
                  wpend <= 1'b1;
                  wdata <= {cmd_addr, nb};
               end
            end
            if (s_fall && tx_on) begin
               // drive from the falling edge after the command
               oe_n <= 1'b0;
               if (left != 6'h00) begin
                  miso <= sh[31];
                  sh <= {sh[30:0], 1'b0};
                  left <= left - 6'h01;
               end else if (burst && bidx != `AS_BURST_LAST) begin
                  // next output register, no new command
                  miso <= nxt_val[31];
                  sh <= {nxt_val[30:0], 1'b0};
                  left <= width_of(nxt_addr) - 6'h01;
                  bidx <= bidx + 3'h1;
               end else begin
                  miso <= 1'b0;
               end
            end
         end
      end
   end
   // Write bytes queue here; the drain holds off while a control bit is live
   as_fifo #(
      .W(13),
      .D(4),
      .AW(2)
   ) u_wfifo (
      .clk(CLK),
      .rst(RST),
      .in_valid(wpend),
      .in_ready(f_in_ready),
      .in_data(wdata),
      .out_valid(f_out_valid),
      .out_ready(f_out_ready),
      .out_data(f_out_data)
   );
   // Drain ready only when no control bit is live
   assign f_out_ready = (sync_ctl == 2'b00);
   // Register file writes
   always @(posedge CLK) begin
      if (RST) begin
         cfg <= `AS_CFG_RST;
         clo <= 8'h00;
         chi <= 4'h0;
         sync_ctl <= 2'b00;
         ld_start <= 1'b0;
      end else begin
         // control bits last one core cycle
         sync_ctl <= 2'b00;
         ld_start <= 1'b0;
         if (f_out_valid && f_out_ready) begin
            case (f_out_data[12:8])
               `AS_A_CFG: cfg <= f_out_data[7:0];
               // low byte first, high byte loads
               `AS_A_CLO: clo <= f_out_data[7:0];
               `AS_A_CHI: begin
                  chi <= f_out_data[3:0];
                  ld_start <= 1'b1;
               end
               `AS_A_SYNC: sync_ctl <= f_out_data[1:0];
               default: sync_ctl <= 2'b00;
            endcase
         end
      end
   end
   // Period counter, sample latch, capture and ready strobe
   always @(posedge CLK) begin
      if (RST) begin
         cnt <= `AS_RELOAD0;
         rdy_cnt <= 7'h00;
         snap_q <= 12'h000;
         cur_q <= 24'h000000;
         v1_q <= 24'h000000;
         v2_q <= 24'h000000;
         crc_q <= 16'h0000;
         stat_q <= 8'h00;
      end else begin
         if (sync_ctl[`AS_SNAP_BIT]) begin
            snap_q <= cnt;
         end
         if (sync_ctl[`AS_SYNC_BIT] || cnt == 12'h000) begin
            cnt <= reload_of(cfg[`AS_CFG_RATE_HI:`AS_CFG_RATE_LO]);
            rdy_cnt <= `AS_RDY_CYC;
            cur_q <= CUR_SAMPLE;
            v1_q <= V1_SAMPLE;
            v2_q <= V2_SAMPLE;
            crc_q <= CRC_WORD;
            stat_q <= STATUS_WORD;
         end else begin
            // count down, or restart from written start
            if (ld_start) begin
               cnt <= {chi, clo};
            end else begin
               cnt <= cnt - 12'h001;
            end
            if (rdy_cnt != 7'h00) begin
               rdy_cnt <= rdy_cnt - 7'h01;
            end
         end
      end
   end
   // Clock mode gives CLK/2, since a flop cannot pass CLK itself
   always @(posedge CLK) begin
      if (RST) begin
         clk_div <= 1'b0;
         pin_q <= 1'b1;
      end else begin
         clk_div <= ~clk_div;
         if (cfg[`AS_CFG_CLKSEL]) begin
            pin_q <= clk_div;
         end else begin
            pin_q <= (rdy_cnt == 7'h00);
         end
      end
   end
   // Pins come straight from flops
   assign MISO = miso;
   assign MISO_OE_N = oe_n;
   assign CLK_OR_RDY = pin_q;
endmodule

// ### testbench/as_port_sva.sv
/*
 Checker for the serial port: output release, read drive and ready pin.
 Assumes binding onto as_port with core clock CLK and reset RST.
*/
`timescale 1ns/1ns
module as_port_sva (
   input wire CLK,
   input wire RST,
   input wire CS_N,
   input wire SCLK,
   input wire MOSI,
   input wire MISO,
   input wire MISO_OE_N,
   input wire CLK_OR_RDY
);
   reg sclk_q;
   reg [3:0] rises;
   reg [7:0] cmd;
   reg [6:0] low_len;
   default clocking @(posedge CLK);
   endclocking
   default disable iff (RST);
   // Raw pin edges, ahead of the port's synchroniser on purpose
   always @(posedge CLK) begin
      sclk_q <= SCLK;
      if (RST || CS_N) begin
         rises <= 4'h0;
         cmd <= 8'h00;
      end else if (SCLK && !sclk_q && rises != 4'h8) begin
         rises <= rises + 4'h1;
         cmd <= {cmd[6:0], MOSI};
      end
   end
   // Length of the current low run on the ready pin
   always @(posedge CLK) begin
      if (RST || CLK_OR_RDY) begin
         low_len <= 7'h00;
      end else if (low_len != 7'h7F) begin
         low_len <= low_len + 7'h01;
      end
   end
   property p_released;
      CS_N [*6] |-> MISO_OE_N;
   endproperty
   a_released: assert property (p_released)
      else $error("data out driven while deselected");
   property p_abort;
      $rose(CS_N) |-> ##[1:5] MISO_OE_N;
   endproperty
   a_abort: assert property (p_abort)
      else $error("data out not released after deselect");
   property p_after_cmd;
      $fell(MISO_OE_N) |-> rises == 4'h8 && !CS_N;
   endproperty
   a_after_cmd: assert property (p_after_cmd)
      else $error("data out driven before command complete");
   property p_read_only;
      $fell(MISO_OE_N) |-> cmd[2];
   endproperty
   a_read_only: assert property (p_read_only)
      else $error("data out driven during a write");
   property p_on_fall;
      !MISO_OE_N && $past(!MISO_OE_N) && $changed(MISO) |-> $past(!SCLK, 2);
   endproperty
   a_on_fall: assert property (p_on_fall)
      else $error("data out changed away from a falling clock");
   property p_rdy_len;
      $rose(CLK_OR_RDY) |-> low_len == 7'h40 || low_len == 7'h01;
   endproperty
   a_rdy_len: assert property (p_rdy_len)
      else $error("ready strobe length wrong");
   property p_rdy_max;
      low_len <= 7'h40;
   endproperty
   a_rdy_max: assert property (p_rdy_max)
      else $error("ready pin low too long");
   property p_reset;
      $past(RST) |-> MISO_OE_N && CLK_OR_RDY;
   endproperty
   a_reset: assert property (p_reset)
      else $error("pins not idle after reset");
endmodule

// ### testbench/as_host.sv
/*
 Host serial master model: chip select, serial clock and data in.
 Assumes the bench feeds back the pulled-up data-out wire.
*/
`timescale 1ns/1ns
module as_host (
   input wire clk,
   output logic cs_n,
   output logic sclk,
   output logic mosi,
   input wire miso
);
   // Clock stands high outside frames
   initial begin
      cs_n = 1'b1;
      sclk = 1'b1;
      mosi = 1'b1;
   end
   // One frame: command, data byte, then zeros; n bits after the command
   task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, input int n,
         output logic [127:0] rx);
      logic [15:0] tx;
      tx = {cmd, wd};
      rx = '0;
      @(negedge clk);
      cs_n = 1'b0;
      repeat (4) @(negedge clk);
      for (int i = 0; i < 8 + n; i++) begin
         sclk = 1'b0;
         mosi = (i < 16) ? tx[15 - i] : 1'b0;
         repeat (4) @(negedge clk);
         if (i >= 8) rx = {rx[126:0], miso};
         sclk = 1'b1;
         repeat (4) @(negedge clk);
      end
      cs_n = 1'b1;
      mosi = ~mosi;
      repeat (6) @(negedge clk);
   endtask
endmodule

// ### testbench/test_as_port.sv
/*
 Bench for the serial port: reads, bursts, writes and period timing.
 Assumes as_port, as_host and as_port_sva are compiled before it.
*/
`timescale 1ns/1ns
module test_as_port;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cs_n, sclk, mosi, miso, oe_n, rdy;
   logic [23:0] cur = 24'hA5C3E1;
   logic [23:0] v1 = 24'h5A3C1E;
   logic [23:0] v2 = 24'h123456;
   logic [15:0] crc = 16'hBEEF;
   logic [7:0] stat = 8'h81;
   int mismatches = 0;
   int checks = 0;
   int cycles = 0;
   // Pull-up on the shared data-out line
   wire miso_w = oe_n ? 1'b1 : miso;
   as_port uut (.CLK(clk), .RST(rst), .CS_N(cs_n), .SCLK(sclk), .MOSI(mosi),
      .MISO(miso), .MISO_OE_N(oe_n), .CLK_OR_RDY(rdy), .CUR_SAMPLE(cur),
      .V1_SAMPLE(v1), .V2_SAMPLE(v2), .CRC_WORD(crc), .STATUS_WORD(stat));
   as_host host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso(miso_w));
   always #20 clk = ~clk;
   task automatic conclude;
      if (mismatches == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Hang guard, well above the longest period sweep
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         mismatches++;
         $display("CHECK FAILED %0t timeout", $time);
         conclude;
      end
   end
   task automatic cmp(input logic [127:0] got, input logic [127:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [7:0] cmd, input int n, input logic [127:0] exp);
      logic [127:0] r;
      host.xfer(cmd, 8'h00, n, r);
      cmp(r, exp);
   endtask
   // Writes must leave the pulled-up line alone
   task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
      logic [127:0] r;
      host.xfer(cmd, d, 8, r);
      cmp(r, 128'hFF);
   endtask
   task automatic wait_rdy(input int lim, output int c);
      c = 0;
      while (rdy !== 1'b0 && c < lim) begin
         @(negedge clk);
         c++;
      end
   endtask
   // Sync only just after a strobe, so a restart never lands inside one
   task automatic sync_now;
      int c;
      wait_rdy(5000, c);
      while (rdy === 1'b0) @(negedge clk);
      wr(8'h48, 8'h01);
      repeat (4) @(negedge clk);
      cmp(rdy, 1'b0);
   endtask
   // Main sequence
   initial begin
      int c;
      logic b;
      logic [127:0] r;
      repeat (8) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      rd(8'h2C, 8, 128'h00);
      sync_now;
      rd(8'h4C, 8, 128'h00);
      rd(8'h14, 24, v2);
      rd(8'h1F, 16, crc);
      rd(8'h26, 8, stat);
      rd(8'h04, 96, {cur, v1, v2, crc, stat});
      rd(8'h0C, 72, {v1, v2, crc, stat});
      host.xfer(8'h04, 8'h00, 10, r);
      cmp(r, cur[23:14]);
      wr(8'h2B, 8'h20);
      rd(8'h2C, 8, 128'h20);
      host.xfer(8'h28, 8'hFF, 4, r);
      rd(8'h2C, 8, 128'h20);
      // Start value written just after a strobe, well clear of the next one
      wait_rdy(5000, c);
      while (rdy === 1'b0) @(negedge clk);
      wr(8'h38, 8'h30);
      wr(8'h40, 8'h00);
      wait_rdy(100, c);
      cmp(c >= 40 && c <= 52, 1);
      rd(8'h04, 96, {cur, v1, v2, crc, stat});
      wr(8'h48, 8'h02);
      host.xfer(8'h34, 8'h00, 16, r);
      // Capture lands about 978 cycles into a count from 2047
      cmp(r[15:12] === 4'h0 && r[11:0] >= 12'h3C0 && r[11:0] <= 12'h4A0, 1);
      for (int k = 0; k < 4; k++) begin
         wr(8'h28, {2'h0, k[1:0], 4'h0});
         sync_now;
         while (rdy === 1'b0) @(negedge clk);
         wait_rdy(5000, c);
         cmp(c, (512 << k) - 64);
      end
      wr(8'h28, 8'h01);
      @(negedge clk);
      b = rdy;
      @(negedge clk);
      cmp(rdy ^ b, 1);
      wr(8'h28, 8'h00);
      conclude;
   end
endmodule
bind as_port as_port_sva chk (.CLK(CLK), .RST(RST), .CS_N(CS_N), .SCLK(SCLK), .MOSI(MOSI),
   .MISO(MISO), .MISO_OE_N(MISO_OE_N), .CLK_OR_RDY(CLK_OR_RDY));
